// *** logic/cpmc_cfg.svh ***
// offsets, field positions, reset values and codes of the clock and power mode block
`ifndef CPMC_CFG_SVH
`define CPMC_CFG_SVH

`define CPMC_ADDR_W 12
// register indices; the byte address is four times the index
`define CPMC_IDX_CLOCK_CFG 10'h0a3
`define CPMC_IDX_POWER_MODE 10'h0a4
`define CPMC_IDX_LF_CFG 10'h0ad

`define CPMC_CLOCK_CFG_RESET 8'h00
`define CPMC_POWER_MODE_RESET 8'h00
`define CPMC_LF_SRC_RESET 3'h7

// mcu_clock_config fields
`define CPMC_CC_KEEP_XOSC 7
`define CPMC_CC_PIN_BYPASS 6
`define CPMC_CC_START_HI 5
`define CPMC_CC_START_LO 4
`define CPMC_CC_XOSC_IRQ 3
`define CPMC_CC_FREQ_HI 2
`define CPMC_CC_FREQ_LO 0

// oscillator start codes
`define CPMC_START_BOTH 2'h0
`define CPMC_START_RC 2'h1
`define CPMC_START_XOSC 2'h2
`define CPMC_START_RSVD 2'h3

// low_freq_clock_config source codes
`define CPMC_LF_SLOW_XOSC 3'h0
`define CPMC_LF_SLOW_RC 3'h1
`define CPMC_LF_FROM_XOSC 3'h2
`define CPMC_LF_PIN_ANALOG 3'h3
`define CPMC_LF_PIN_DIGITAL 3'h4
`define CPMC_LF_RSVD_A 3'h5
`define CPMC_LF_RSVD_B 3'h6
`define CPMC_LF_NONE 3'h7

`define CPMC_RESP_OKAY 2'h0
`define CPMC_RESP_SLVERR 2'h2

`endif

// *** logic/cpmc_pkg.sv ***
// types of the clock and power mode block
package cpmc_pkg;

  typedef enum logic [2:0] {
    PM_OFF = 3'h0,
    PM_DEEP_SLEEP = 3'h1,
    PM_MEM_RET_TIMER_OFF = 3'h2,
    PM_MEM_RET_TIMER_ON = 3'h3,
    PM_REG_RET = 3'h4,
    PM_RSVD_A = 3'h5,
    PM_RSVD_B = 3'h6,
    PM_STANDBY = 3'h7
  } cpmc_mode_type;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b001,
    ST_DOWN = 3'b010,
    ST_WAKE = 3'b100
  } cpmc_state_type;

endpackage : cpmc_pkg

// *** logic/cpmc_top.sv ***
// clock source, divider and power-down mode control with an AXI4-Lite register slave
// What this block does
// - keep crystal on in register retention when bit7
// - bit6 takes clock straight from crystal pin
// - start field picks which fast oscillators run
// - start field applies only after a sleep mode
// - reset zero; RC first, then crystal automatically
// - bit3 enables crystal-ready wakeup and interrupt
// - frequency field divides clock by powers two
// - low-frequency register bit7 shows clock phase
// - low-frequency register bit6 shows clock ready
// - low-frequency register bit3 shows crystal sourcing
// - low-frequency source field selects clock source
// - crystal-derived low clock stops in deep sleeps
// - no start or wake until low clock toggles, except with low source none
// - wake flags clear on read or power-down
// - nonzero, non-reserved mode write enters that power-down mode
// - mode read returns previous power-down mode
// - both register retention variants use code 100
// - register retention wake gives no system reset
`timescale 1ns/1ps
`include "cpmc_cfg.svh"

module cpmc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CPMC_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`CPMC_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic fast_crystal_osc_ready,
  input wire logic low_freq_clock_level,
  input wire logic wake_pin,
  input wire logic wake_tick,
  input wire logic wake_comp,
  output logic fast_crystal_osc_en,
  output logic fast_rc_osc_en,
  output logic mcu_clk_from_pin,
  output logic mcu_clk_from_crystal,
  output logic [7:0] mcu_clk_div_ratio,
  output logic [2:0] low_freq_src_sel,
  output logic low_freq_clock_en,
  output logic mcu_clock_run,
  output logic wake_system_reset,
  output logic crystal_ready_irq,
  output logic [2:0] power_mode_now
);

  logic [7:0] mcu_clock_config, w_data_held, rd_byte;
  logic [1:0] start_applied, next_start;
  logic [2:0] lf_src, prev_mode, cur_mode, wr_mode;
  logic [9:0] wr_idx, rd_idx;
  logic [`CPMC_ADDR_W-1:0] aw_addr_held;
  logic flag_pin, flag_tick, flag_comp, lf_level, lf_ready, xosc_ready_d;
  logic aw_held, w_lane0, w_held, wr_fire, wr_mapped, rd_fire, rd_pwr, rd_mapped, mode_go;
  logic xosc_rise, wake_any, wake_done, next_xosc_en, next_rc_en, next_lf_en;
  cpmc_pkg::cpmc_state_type state, next_state;

  // write address and write data are caught independently, in either order
  assign wr_fire = aw_held && w_held && !bvalid;
  assign wr_idx = aw_addr_held[`CPMC_ADDR_W-1:2];
  assign wr_mapped = (wr_idx == `CPMC_IDX_CLOCK_CFG) || (wr_idx == `CPMC_IDX_POWER_MODE) ||
                     (wr_idx == `CPMC_IDX_LF_CFG);
  assign rd_fire = arvalid && arready;
  assign rd_idx = araddr[`CPMC_ADDR_W-1:2];
  assign rd_pwr = rd_fire && (rd_idx == `CPMC_IDX_POWER_MODE);
  assign wr_mode = w_data_held[2:0];
  // nonzero, non-reserved mode write while running
  assign mode_go = wr_fire && w_lane0 && (wr_idx == `CPMC_IDX_POWER_MODE) &&
                   (state == cpmc_pkg::ST_ACTIVE) && (wr_mode != cpmc_pkg::PM_OFF) &&
                   (wr_mode != cpmc_pkg::PM_RSVD_A) && (wr_mode != cpmc_pkg::PM_RSVD_B);
  assign xosc_rise = fast_crystal_osc_ready && !xosc_ready_d &&
                     mcu_clock_config[`CPMC_CC_XOSC_IRQ];
  assign wake_any = wake_pin || wake_tick || wake_comp || xosc_rise;
  // wake completes once the low clock toggles, or at once with low source none
  assign wake_done = (lf_src == `CPMC_LF_NONE) || lf_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_held <= 1'b0;
      aw_addr_held <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_held <= 1'b1;
      aw_addr_held <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_held <= 1'b0;
      w_data_held <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_held <= 1'b1;
      w_data_held <= wdata[7:0];
      w_lane0 <= wstrb[0];
    end else if (bvalid && bready) begin
      wready <= 1'b1;
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `CPMC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? `CPMC_RESP_OKAY : `CPMC_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_mapped = 1'b1;
    rd_byte = 8'h00;
    if (rd_idx == `CPMC_IDX_CLOCK_CFG) begin
      rd_byte = mcu_clock_config;
    end else if (rd_idx == `CPMC_IDX_POWER_MODE) begin
      // mode field reads back the previous mode
      rd_byte = {flag_pin, flag_tick, flag_comp, 2'b00, prev_mode};
    end else if (rd_idx == `CPMC_IDX_LF_CFG) begin
      rd_byte = {lf_level, lf_ready, 2'b00, mcu_clk_from_crystal, lf_src};
    end else begin
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `CPMC_RESP_OKAY;
    end else if (rd_fire) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_byte};
      rresp <= rd_mapped ? `CPMC_RESP_OKAY : `CPMC_RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mcu_clock_config <= `CPMC_CLOCK_CFG_RESET;
    end else if (wr_fire && w_lane0 && (wr_idx == `CPMC_IDX_CLOCK_CFG)) begin
      mcu_clock_config <= w_data_held;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_src <= `CPMC_LF_SRC_RESET;
    end else if (wr_fire && w_lane0 && (wr_idx == `CPMC_IDX_LF_CFG) &&
                 (w_data_held[2:0] != `CPMC_LF_RSVD_A) &&
                 (w_data_held[2:0] != `CPMC_LF_RSVD_B)) begin
      lf_src <= w_data_held[2:0];
    end
  end

  // start field takes effect on entry to a retention or deep sleep mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_applied <= `CPMC_START_BOTH;
    end else if (mode_go && (wr_mode != cpmc_pkg::PM_STANDBY) &&
                 (mcu_clock_config[`CPMC_CC_START_HI:`CPMC_CC_START_LO] != `CPMC_START_RSVD)) begin
      start_applied <= mcu_clock_config[`CPMC_CC_START_HI:`CPMC_CC_START_LO];
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      cpmc_pkg::ST_ACTIVE: begin
        if (mode_go) begin
          next_state = cpmc_pkg::ST_DOWN;
        end
      end
      cpmc_pkg::ST_DOWN: begin
        if (wake_any) begin
          next_state = cpmc_pkg::ST_WAKE;
        end
      end
      cpmc_pkg::ST_WAKE: begin
        if (wake_done) begin
          next_state = cpmc_pkg::ST_ACTIVE;
        end
      end
      default: next_state = cpmc_pkg::ST_ACTIVE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= cpmc_pkg::ST_WAKE;
    end else begin
      state <= next_state;
    end
  end

  // code 100 serves both register retention variants
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_mode <= cpmc_pkg::PM_OFF;
      prev_mode <= cpmc_pkg::PM_OFF;
    end else if (mode_go) begin
      cur_mode <= wr_mode;
      prev_mode <= wr_mode;
    end else if ((state == cpmc_pkg::ST_WAKE) && wake_done) begin
      cur_mode <= cpmc_pkg::PM_OFF;
    end
  end

  // flags set on wake, cleared by read or power-down; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_pin <= 1'b0;
      flag_tick <= 1'b0;
      flag_comp <= 1'b0;
    end else if (state == cpmc_pkg::ST_DOWN) begin
      flag_pin <= flag_pin || wake_pin;
      flag_tick <= flag_tick || wake_tick;
      flag_comp <= flag_comp || wake_comp;
    end else if (mode_go || rd_pwr) begin
      flag_pin <= 1'b0;
      flag_tick <= 1'b0;
      flag_comp <= 1'b0;
    end
  end

  always_comb begin
    next_start = start_applied;
    if (next_state == cpmc_pkg::ST_DOWN && mode_go && (wr_mode != cpmc_pkg::PM_STANDBY) &&
        (mcu_clock_config[`CPMC_CC_START_HI:`CPMC_CC_START_LO] != `CPMC_START_RSVD)) begin
      next_start = mcu_clock_config[`CPMC_CC_START_HI:`CPMC_CC_START_LO];
    end
    next_xosc_en = (next_start == `CPMC_START_BOTH) || (next_start == `CPMC_START_XOSC);
    next_rc_en = (next_start == `CPMC_START_BOTH) || (next_start == `CPMC_START_RC);
    if (next_state == cpmc_pkg::ST_DOWN) begin
      if (mode_go ? (wr_mode == cpmc_pkg::PM_REG_RET) : (cur_mode == cpmc_pkg::PM_REG_RET)) begin
        next_xosc_en = next_xosc_en && mcu_clock_config[`CPMC_CC_KEEP_XOSC];
        next_rc_en = 1'b0;
      end else if (mode_go ? (wr_mode != cpmc_pkg::PM_STANDBY)
                           : (cur_mode != cpmc_pkg::PM_STANDBY)) begin
        next_xosc_en = 1'b0;
        next_rc_en = 1'b0;
      end
    end
    // crystal-derived low clock follows the crystal
    next_lf_en = (lf_src != `CPMC_LF_NONE) &&
                 !((lf_src == `CPMC_LF_FROM_XOSC) && !next_xosc_en);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_crystal_osc_en <= 1'b1;
      fast_rc_osc_en <= 1'b1;
      low_freq_clock_en <= 1'b0;
    end else begin
      fast_crystal_osc_en <= next_xosc_en;
      fast_rc_osc_en <= next_rc_en;
      low_freq_clock_en <= next_lf_en;
    end
  end

  // ready once an edge is seen on the running low clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_level <= 1'b0;
      lf_ready <= 1'b0;
    end else begin
      lf_level <= low_freq_clock_level;
      if (!low_freq_clock_en || (wr_fire && w_lane0 && (wr_idx == `CPMC_IDX_LF_CFG))) begin
        lf_ready <= 1'b0;
      end else if (low_freq_clock_level != lf_level) begin
        lf_ready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xosc_ready_d <= 1'b0;
      crystal_ready_irq <= 1'b0;
    end else begin
      xosc_ready_d <= fast_crystal_osc_ready;
      crystal_ready_irq <= xosc_rise;
    end
  end

  // pin bypass; switch to crystal once it runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mcu_clk_from_pin <= 1'b0;
      mcu_clk_from_crystal <= 1'b0;
    end else begin
      mcu_clk_from_pin <= mcu_clock_config[`CPMC_CC_PIN_BYPASS];
      mcu_clk_from_crystal <= next_xosc_en && fast_crystal_osc_ready;
    end
  end

  // ratio is two to the power of the code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mcu_clk_div_ratio <= 8'h01;
    end else begin
      mcu_clk_div_ratio <= 8'h01 << mcu_clock_config[`CPMC_CC_FREQ_HI:`CPMC_CC_FREQ_LO];
    end
  end

  // only deep sleep and memory retention wake through reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_system_reset <= 1'b0;
      mcu_clock_run <= 1'b0;
      low_freq_src_sel <= `CPMC_LF_SRC_RESET;
      power_mode_now <= cpmc_pkg::PM_OFF;
    end else begin
      wake_system_reset <= (state == cpmc_pkg::ST_WAKE) && wake_done &&
                           ((cur_mode == cpmc_pkg::PM_DEEP_SLEEP) ||
                            (cur_mode == cpmc_pkg::PM_MEM_RET_TIMER_OFF) ||
                            (cur_mode == cpmc_pkg::PM_MEM_RET_TIMER_ON));
      mcu_clock_run <= (next_state == cpmc_pkg::ST_ACTIVE);
      low_freq_src_sel <= lf_src;
      power_mode_now <= mode_go ? wr_mode :
                        ((state == cpmc_pkg::ST_WAKE) && wake_done) ? cpmc_pkg::PM_OFF : cur_mode;
    end
  end

endmodule : cpmc_top

// *** bench/cpmc_chk.sv ***
// port assertions of the clock and power mode control block
`timescale 1ns/1ps
`include "cpmc_cfg.svh"

module cpmc_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CPMC_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic fast_crystal_osc_ready,
  input wire logic fast_crystal_osc_en,
  input wire logic fast_rc_osc_en,
  input wire logic mcu_clk_from_pin,
  input wire logic mcu_clk_from_crystal,
  input wire logic [7:0] mcu_clk_div_ratio,
  input wire logic [2:0] low_freq_src_sel,
  input wire logic low_freq_clock_en,
  input wire logic mcu_clock_run,
  input wire logic wake_system_reset,
  input wire logic crystal_ready_irq,
  input wire logic [2:0] power_mode_now
);
  logic [2:0] last_down;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // mode the block last slept in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_down <= 3'h0;
    end else if (power_mode_now != 3'h0) begin
      last_down <= power_mode_now;
    end
  end

  sequence both_taken_s;
    awvalid && awready && wvalid && wready && wstrb[0];
  endsequence
  sequence cc_wr_s;
    both_taken_s ##0 awaddr == {`CPMC_IDX_CLOCK_CFG, 2'h0};
  endsequence
  sequence pm_wr_s;
    both_taken_s ##0 (awaddr == {`CPMC_IDX_POWER_MODE, 2'h0} && mcu_clock_run
      && wdata[2:0] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h7});
  endsequence

  pin_bypass_a: assert property (cc_wr_s |=> ##2 mcu_clk_from_pin == $past(wdata[6], 3))
    else $error("pin bypass output wrong after write");
  div_ratio_a: assert property (cc_wr_s |=> ##2
    mcu_clk_div_ratio == 8'h01 << $past(wdata[2:0], 3))
    else $error("divide ratio wrong after write");
  mode_entry_a: assert property (pm_wr_s |=> ##1
    (!mcu_clock_run && power_mode_now == $past(wdata[2:0], 2)))
    else $error("power-down mode not entered");
  no_reg_reset_a: assert property (wake_system_reset |-> last_down inside {3'h1, 3'h2, 3'h3})
    else $error("system reset on wake from register retention or standby");
  irq_pulse_a: assert property (crystal_ready_irq |->
    $past(fast_crystal_osc_ready) ##1 !crystal_ready_irq)
    else $error("crystal ready pulse without ready crystal");
  xtal_source_a: assert property (mcu_clk_from_crystal |-> $past(fast_crystal_osc_ready))
    else $error("clock from crystal that is not running");
  lf_from_xtal_a: assert property ((low_freq_src_sel == 3'h2) && !fast_crystal_osc_en
    && $past(!fast_crystal_osc_en) |-> !low_freq_clock_en)
    else $error("derived slow clock runs with crystal off");
  reset_osc_a: assert property ($rose(aresetn) |-> fast_crystal_osc_en && fast_rc_osc_en
    && mcu_clk_div_ratio == 8'h01)
    else $error("oscillators or divider wrong after reset");
endmodule : cpmc_chk

bind cpmc_top cpmc_chk chk_i (
  .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
  .fast_crystal_osc_ready, .fast_crystal_osc_en, .fast_rc_osc_en, .mcu_clk_from_pin,
  .mcu_clk_from_crystal, .mcu_clk_div_ratio, .low_freq_src_sel, .low_freq_clock_en,
  .mcu_clock_run, .wake_system_reset, .crystal_ready_irq, .power_mode_now
);

// *** bench/clock_and_power_mode_control_bench.sv ***
// self-checking bench of the clock and power mode control block
`timescale 1ns/1ps
`include "cpmc_cfg.svh"

module clock_and_power_mode_control_bench;
  localparam logic [11:0] A_CC = {`CPMC_IDX_CLOCK_CFG, 2'h0};
  localparam logic [11:0] A_PM = {`CPMC_IDX_POWER_MODE, 2'h0};
  localparam logic [11:0] A_LF = {`CPMC_IDX_LF_CFG, 2'h0};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic xrdy = 1'b0;
  logic lvl = 1'b0;
  logic [2:0] wk = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, fx_en, rc_en, from_pin, from_x, run, rst, irq;
  logic sr;
  logic lf_en;
  logic [2:0] lf_sel;
  logic [3:0] strb = 4'h1;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rdv;
  logic [7:0] div;
  logic [2:0] pm_now;
  int miscompares = 0;
  int checks_done = 0;
  int k;

  cpmc_top uut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(strb), .wvalid, .wready,
    .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready(1'b1), .fast_crystal_osc_ready(xrdy), .low_freq_clock_level(lvl),
    .wake_pin(wk[2]), .wake_tick(wk[1]), .wake_comp(wk[0]), .fast_crystal_osc_en(fx_en),
    .fast_rc_osc_en(rc_en), .mcu_clk_from_pin(from_pin), .mcu_clk_from_crystal(from_x),
    .mcu_clk_div_ratio(div), .low_freq_src_sel(lf_sel), .low_freq_clock_en(lf_en),
    .mcu_clock_run(run), .wake_system_reset(rst), .crystal_ready_irq(irq),
    .power_mode_now(pm_now)
  );

  always #20 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdv = rdata;
    resp = rresp;
  endtask : rd

  task automatic down(input logic [2:0] m);
    wr(A_PM, {5'h0, m});
    repeat (2) @(posedge aclk);
    sr = 1'b0;
  endtask : down

  // pulse one wake source (3 = none), then wait for the clock to run
  task automatic wake(input int j);
    wk <= 3'(1 << j);
    @(posedge aclk);
    wk <= 3'h0;
    for (int n = 0; n < 60 && run !== 1'b1; n++) begin
      @(posedge aclk);
      if (rst === 1'b1) sr = 1'b1;
    end
  endtask : wake

  task automatic count_irq();
    k = 0;
    repeat (10) begin
      @(posedge aclk);
      if (irq === 1'b1) k++;
    end
  endtask : count_irq

  task automatic t_reset();
    rd(A_CC);
    chk(rdv, 32'h0);
    rd(A_PM);
    chk(rdv, 32'h0);
    rd(A_LF);
    chk(rdv, 32'h7);
    chk({fx_en, rc_en, div}, 10'h301);
    rd(12'h004);
    chk(rdv, 32'h0);
    chk(resp, `CPMC_RESP_SLVERR);
    wr(12'h008, 8'hff);
    chk(resp, `CPMC_RESP_SLVERR);
    strb <= 4'h0;
    wr(A_CC, 8'hff);
    strb <= 4'h1;
    chk(resp, `CPMC_RESP_OKAY);
    rd(A_CC);
    chk(rdv, 32'h0);
    $display("done reset");
  endtask : t_reset

  task automatic t_cfg();
    for (int f = 0; f < 8; f++) begin
      wr(A_CC, {1'b0, f[0], 3'h0, f[2:0]});
      repeat (2) @(posedge aclk);
      chk(div, 8'h01 << f);
      chk(from_pin, f[0]);
      rd(A_CC);
      chk(rdv, {f[0], 3'h0, f[2:0]});
    end
    wr(A_CC, 8'h00);
    $display("done clock config");
  endtask : t_cfg

  task automatic t_modes();
    logic [2:0] ms [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    for (int i = 0; i < 5; i++) begin
      down(ms[i]);
      chk({run, pm_now}, {1'b0, ms[i]});
      wake(i % 3);
      chk(run, 1'b1);
      chk(sr, ms[i] inside {3'h1, 3'h2, 3'h3});
      rd(A_PM);
      chk(rdv, {3'(1 << (i % 3)), 2'h0, ms[i]});
      rd(A_PM);
      chk(rdv, ms[i]);
      wr(A_PM, 8'h00);
    end
    wr(A_PM, 8'h05);
    repeat (2) @(posedge aclk);
    chk(run, 1'b1);
    rd(A_PM);
    chk(rdv, 32'h7);
    $display("done power modes");
  endtask : t_modes

  task automatic t_start();
    wr(A_CC, 8'h10);
    repeat (2) @(posedge aclk);
    chk(fx_en, 1'b1);
    down(3'h1);
    wake(2);
    chk({fx_en, rc_en}, 2'h1);
    wr(A_CC, 8'h20);
    down(3'h1);
    wake(2);
    chk({fx_en, rc_en}, 2'h2);
    wr(A_CC, 8'h80);
    down(3'h4);
    chk(fx_en, 1'b1);
    wake(2);
    chk({fx_en, rc_en}, 2'h3);
    wr(A_CC, 8'h00);
    down(3'h4);
    chk(fx_en, 1'b0);
    wake(2);
    $display("done oscillator start");
  endtask : t_start

  task automatic t_irq();
    wr(A_CC, 8'h08);
    xrdy <= 1'b1;
    count_irq();
    chk(k, 1);
    chk(from_x, 1'b1);
    rd(A_LF);
    chk(rdv, 32'hf);
    xrdy <= 1'b0;
    wr(A_CC, 8'h00);
    xrdy <= 1'b1;
    count_irq();
    chk(k, 0);
    $display("done crystal ready");
  endtask : t_irq

  task automatic t_lf();
    for (int c = 0; c < 8; c++) begin
      wr(A_LF, 8'(c));
      rd(A_LF);
      chk(rdv & 32'h7, (c == 5 || c == 6) ? 32'h4 : c);
      chk(lf_sel, (c == 5 || c == 6) ? 3'h4 : 3'(c));
    end
    wr(A_LF, 8'h01);
    lvl <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(lf_en, 1'b1);
    rd(A_LF);
    chk(rdv & 32'hc7, 32'hc1);
    wr(A_LF, 8'h01);
    down(3'h4);
    wake(2);
    chk(run, 1'b0);
    lvl <= 1'b0;
    wake(3);
    chk(run, 1'b1);
    wr(A_LF, 8'h02);
    down(3'h1);
    chk({lf_sel, lf_en, fx_en}, 5'h08);
    wake(2);
    chk(run, 1'b0);
    lvl <= 1'b1;
    wake(3);
    chk({run, sr}, 2'h3);
    wr(A_LF, 8'h07);
    $display("done low clock");
  endtask : t_lf

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_cfg();
    t_modes();
    t_start();
    t_irq();
    t_lf();
    results();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    results();
  end
endmodule : clock_and_power_mode_control_bench
